// *** sph_pkg.sv ***
// package: constants and carriers for the sts-1 pointer slip handler
package sph_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam logic [6:0] COL_LAST = 7'h59;
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam logic [3:0] PTR_ROW = 4'h3;
  localparam logic [6:0] H1_COL = 7'h00;
  localparam logic [6:0] H2_COL = 7'h01;
  localparam logic [6:0] H3_COL = 7'h02;
  localparam logic [6:0] ENV_COL = 7'h03;
  localparam logic [7:0] FRAME_A = 8'hf6;
  localparam logic [7:0] FRAME_B = 8'h28;
  localparam logic [1:0] MISS_LIMIT = 2'h2;

  // ----------------------------------------------------------------
  // pointer word
  // ----------------------------------------------------------------
  localparam logic [15:0] PTR_FIELD = 16'h03ff;
  localparam logic [9:0] PTR_MAX = 10'h30f;
  localparam logic [9:0] INC_MASK = 10'h2aa;
  localparam logic [9:0] DEC_MASK = 10'h155;
  localparam logic [3:0] FLIP_VOTE = 4'h3;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // slip buffer
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int LOW_WATER = 4;

  typedef enum logic [1:0] {
    SPH_HUNT = 2'b01,
    SPH_LOCK = 2'b10
  } sph_sync_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic stuff;
    logic spe;
    logic j1;
  } sph_byte_type;

  typedef struct packed {
    logic in_frame;
    logic ptr_invalid;
    logic inc;
    logic dec;
    logic slip;
    logic [9:0] pointer;
  } sph_ptr_type;

endpackage

// *** sph_slip_ram.sv ***
// slip buffer storage: line-clock write port, registered local-clock read port
`timescale 1ns/1ns
module sph_slip_ram #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
) (
  input wire logic i_wr_clock,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_rd_clock,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);
  logic [DATA_W-1:0] mem_ff [2**ADDR_W];
  logic [DATA_W-1:0] rd_data_ff;

  always_ff @(posedge i_wr_clock) begin
    if (i_wr_en) begin
      mem_ff[i_wr_addr] <= i_wr_data;
    end
  end

  // an address read here on a pop is never one being written: the gray pointers keep them apart
  always_ff @(posedge i_rd_clock) begin
    rd_data_ff <= mem_ff[i_rd_addr];
  end

  assign o_rd_data = rd_data_ff;
endmodule

// *** sph_pointer_rx.sv ***
// sts-1 receive pointer processing behind a two-clock slip buffer
// How it works
// [R1] the pointer word is the h1 byte on top of the h2 byte, sixteen bits.
// [R2] the low ten bits of that word give the j1 offset in the envelope.
// [R3] j1 is the first spe byte and payload marking starts there.
// [R4] a pointer of zero puts j1 in the envelope byte right after h3.
// [R5] a ten-bit value above 0x30f that is not read as an inc or dec is invalid and never moves the payload.
// [R6] pointer bytes are read only while frame lock is held.
// [R7] line bytes are written into the slip buffer on the line clock.
// [R8] bytes leave the slip buffer on the local clock, unrelated to the line clock.
// [R9] with equal rates the fill stays put and no adjustment is made.
// [R10] a read with the buffer near empty yields a dummy stuff byte instead.
// [R11] every stuffed byte is kept out of the payload; only dummy bytes are flagged as stuff.
// [R12] an inc frame has inverted i bits and a stuff byte right after h3.
// [R13] after an inc frame the pointer is one higher.
// [R14] a dec frame has inverted d bits and carries a payload byte in h3.
// [R15] after a dec frame the pointer is one lower.
// [R16] an invalid pointer raises a flag and the last valid position is kept.
`timescale 1ns/1ns
module sph_pointer_rx #(
  parameter int ADDR_W = sph_pkg::ADDR_W,
  parameter int LOW_WATER = sph_pkg::LOW_WATER
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_line_clock,
  input wire logic [7:0] i_line_data,
  input wire logic i_out_req,
  output sph_pkg::sph_byte_type o_byte,
  output sph_pkg::sph_ptr_type o_ptr
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W:0] g2b(input logic [ADDR_W:0] g);
    logic [ADDR_W:0] b;
    b = g;
    for (int k = ADDR_W - 1; k >= 0; k--) begin
      b[k] = b[k+1] ^ g[k];
    end
    return b;
  endfunction

  function automatic logic [ADDR_W:0] b2g(input logic [ADDR_W:0] b);
    return b ^ (b >> 1);
  endfunction

  // votes on how many indicator bits came in inverted
  function automatic logic flipped(input logic [9:0] diff, input logic [9:0] mask);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 10; k++) begin
      n = n + {3'h0, diff[k] & mask[k]};
    end
    return n >= sph_pkg::FLIP_VOTE;
  endfunction

  // ----------------------------------------------------------------
  // line clock side
  // ----------------------------------------------------------------
  logic lrst_meta_ff;
  logic lrst_ff;
  logic [ADDR_W:0] wbin_ff;
  logic [ADDR_W:0] wgray_ff;
  logic [ADDR_W:0] rg_meta_ff;
  logic [ADDR_W:0] rg_sync_ff;
  logic [ADDR_W:0] rgray_ff;
  logic [ADDR_W:0] wfill;
  logic wr_en;
  logic wslip_tgl_ff;

  // the reset level is brought into the line domain before anything uses it
  always_ff @(posedge i_line_clock) begin
    lrst_meta_ff <= ~i_rstn;
    lrst_ff <= lrst_meta_ff;
  end

  assign wfill = wbin_ff - g2b(rg_sync_ff);
  assign wr_en = ~lrst_ff & ~wfill[ADDR_W];

  always_ff @(posedge i_line_clock) begin
    if (lrst_ff) begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end else if (wr_en) begin
      wbin_ff <= wbin_ff + 1'b1; // [R7]
      wgray_ff <= b2g(wbin_ff + 1'b1);
    end
  end

  // a byte met with a full buffer is lost; the toggle tells the local side
  always_ff @(posedge i_line_clock) begin
    if (lrst_ff) begin
      wslip_tgl_ff <= 1'b0;
    end else if (wfill[ADDR_W]) begin
      wslip_tgl_ff <= ~wslip_tgl_ff;
    end
  end

  always_ff @(posedge i_line_clock) begin
    if (lrst_ff) begin
      rg_meta_ff <= '0;
      rg_sync_ff <= '0;
    end else begin
      rg_meta_ff <= rgray_ff;
      rg_sync_ff <= rg_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // local clock side: buffer read
  // ----------------------------------------------------------------
  logic [ADDR_W:0] rbin_ff;
  logic [ADDR_W:0] wg_meta_ff;
  logic [ADDR_W:0] wg_sync_ff;
  logic [ADDR_W:0] fill;
  logic pop;
  logic dummy;
  logic s1_pop_ff;
  logic s1_dummy_ff;
  logic [7:0] cur;
  logic [2:0] slip_sync_ff;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wg_meta_ff <= '0;
      wg_sync_ff <= '0;
      slip_sync_ff <= 3'h0;
    end else begin
      wg_meta_ff <= wgray_ff;
      wg_sync_ff <= wg_meta_ff;
      slip_sync_ff <= {slip_sync_ff[1:0], wslip_tgl_ff};
    end
  end

  assign fill = g2b(wg_sync_ff) - rbin_ff;
  // held at the low water mark, so equal rates never call for a dummy byte
  assign pop = i_out_req & (fill > (ADDR_W + 1)'(LOW_WATER)); // [R9]
  assign dummy = i_out_req & ~pop; // [R10]

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rbin_ff <= '0;
      rgray_ff <= '0;
    end else if (pop) begin
      rbin_ff <= rbin_ff + 1'b1; // [R8]
      rgray_ff <= b2g(rbin_ff + 1'b1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      s1_pop_ff <= 1'b0;
      s1_dummy_ff <= 1'b0;
    end else begin
      s1_pop_ff <= pop;
      s1_dummy_ff <= dummy;
    end
  end

  sph_slip_ram #(
    .ADDR_W(ADDR_W),
    .DATA_W(8)
  ) u_ram (
    .i_wr_clock(i_line_clock),
    .i_wr_en(wr_en),
    .i_wr_addr(wbin_ff[ADDR_W-1:0]),
    .i_wr_data(i_line_data),
    .i_rd_clock(i_clock),
    .i_rd_addr(rbin_ff[ADDR_W-1:0]),
    .o_rd_data(cur)
  );

  // ----------------------------------------------------------------
  // frame lock
  // ----------------------------------------------------------------
  sph_pkg::sph_sync_type state_ff;
  logic [6:0] col_ff;
  logic [3:0] row_ff;
  logic [7:0] prev_ff;
  logic [1:0] miss_ff;
  logic lock;
  logic word_ok;

  assign lock = s1_pop_ff & (state_ff == sph_pkg::SPH_LOCK);
  assign word_ok = (prev_ff == sph_pkg::FRAME_A) & (cur == sph_pkg::FRAME_B);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      prev_ff <= 8'h00;
    end else if (s1_pop_ff) begin
      prev_ff <= cur;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_ff <= sph_pkg::SPH_HUNT;
      col_ff <= 7'h00;
      row_ff <= 4'h0;
      miss_ff <= 2'h0;
    end else if (s1_pop_ff) begin
      case (state_ff)
        sph_pkg::SPH_HUNT: begin
          if (word_ok) begin
            state_ff <= sph_pkg::SPH_LOCK; // [R6]
            col_ff <= sph_pkg::H3_COL;
            row_ff <= 4'h0;
            miss_ff <= 2'h0;
          end
        end
        sph_pkg::SPH_LOCK: begin
          if (col_ff == sph_pkg::COL_LAST) begin
            col_ff <= 7'h00;
            row_ff <= (row_ff == sph_pkg::ROW_LAST) ? 4'h0 : row_ff + 4'h1;
          end else begin
            col_ff <= col_ff + 7'h01;
          end
          if (row_ff == 4'h0 && col_ff == sph_pkg::H2_COL) begin
            if (word_ok) begin
              miss_ff <= 2'h0;
            end else if (miss_ff + 2'h1 == sph_pkg::MISS_LIMIT) begin
              state_ff <= sph_pkg::SPH_HUNT;
            end else begin
              miss_ff <= miss_ff + 2'h1;
            end
          end
        end
        default: begin
          state_ff <= sph_pkg::SPH_HUNT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pointer interpretation
  // ----------------------------------------------------------------
  sph_pkg::sph_ptr_type stat_ff;
  logic [7:0] h1_ff;
  logic ptr_ok_ff;
  logic inc_frame_ff;
  logic dec_frame_ff;
  logic [15:0] word;
  logic [9:0] val;
  logic h2_hit;
  logic inc_hit;
  logic dec_hit;

  assign word = {h1_ff, cur}; // [R1]
  assign val = 10'(word & sph_pkg::PTR_FIELD); // [R2]
  assign h2_hit = lock & (row_ff == sph_pkg::PTR_ROW) & (col_ff == sph_pkg::H2_COL);
  assign inc_hit = ptr_ok_ff & flipped(val ^ stat_ff.pointer, sph_pkg::INC_MASK);
  assign dec_hit = ptr_ok_ff & ~inc_hit & flipped(val ^ stat_ff.pointer, sph_pkg::DEC_MASK);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      h1_ff <= 8'h00;
    end else if (lock && row_ff == sph_pkg::PTR_ROW && col_ff == sph_pkg::H1_COL) begin
      h1_ff <= cur; // [R6]
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      stat_ff <= '0;
      ptr_ok_ff <= 1'b0;
      inc_frame_ff <= 1'b0;
      dec_frame_ff <= 1'b0;
    end else begin
      stat_ff.in_frame <= (state_ff == sph_pkg::SPH_LOCK);
      stat_ff.inc <= h2_hit & inc_hit;
      stat_ff.dec <= h2_hit & dec_hit;
      stat_ff.slip <= slip_sync_ff[2] ^ slip_sync_ff[1];
      if (h2_hit) begin
        inc_frame_ff <= inc_hit; // [R12]
        dec_frame_ff <= dec_hit; // [R14]
        if (inc_hit) begin
          stat_ff.pointer <= (stat_ff.pointer == sph_pkg::PTR_MAX) ? 10'h000
                             : stat_ff.pointer + 10'h001; // [R13]
        end else if (dec_hit) begin
          stat_ff.pointer <= (stat_ff.pointer == 10'h000) ? sph_pkg::PTR_MAX
                             : stat_ff.pointer - 10'h001; // [R15]
        end else if (val > sph_pkg::PTR_MAX) begin
          stat_ff.ptr_invalid <= 1'b1; // [R5] [R16]
        end else begin
          stat_ff.pointer <= val;
          stat_ff.ptr_invalid <= 1'b0;
          ptr_ok_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // envelope position and payload marking
  // ----------------------------------------------------------------
  logic [9:0] ec_ff;
  logic [9:0] env_idx;
  logic spe_on_ff;
  logic at_env0;
  logic at_h3;
  logic env_byte;
  logic j1_hit;
  logic pay_byte;
  sph_pkg::sph_byte_type byte_ff;

  assign at_env0 = (row_ff == sph_pkg::PTR_ROW) & (col_ff == sph_pkg::ENV_COL);
  assign at_h3 = (row_ff == sph_pkg::PTR_ROW) & (col_ff == sph_pkg::H3_COL);
  assign env_byte = (col_ff >= sph_pkg::ENV_COL);
  assign env_idx = at_env0 ? 10'h000 : ec_ff; // [R4]
  // the stuff byte of an inc frame sits at envelope 0 and never becomes j1
  assign j1_hit = lock & ptr_ok_ff & env_byte & (env_idx == stat_ff.pointer)
                  & ~(inc_frame_ff & at_env0); // [R3]
  assign pay_byte = lock & (spe_on_ff | j1_hit)
                    & ((env_byte & ~(inc_frame_ff & at_env0)) // [R12]
                       | (dec_frame_ff & at_h3)); // [R14]

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ec_ff <= 10'h000;
      spe_on_ff <= 1'b0;
    end else if (s1_pop_ff) begin
      if (lock && env_byte) begin
        ec_ff <= env_idx + 10'h001;
      end
      if (!lock) begin
        spe_on_ff <= 1'b0;
      end else if (j1_hit) begin
        spe_on_ff <= 1'b1; // [R3]
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      byte_ff <= '0;
    end else begin
      byte_ff.valid <= s1_pop_ff | s1_dummy_ff;
      byte_ff.data <= s1_pop_ff ? cur : sph_pkg::DUMMY_BYTE;
      byte_ff.stuff <= s1_dummy_ff; // [R11]
      byte_ff.spe <= pay_byte; // [R11]
      byte_ff.j1 <= j1_hit;
    end
  end

  assign o_byte = byte_ff;
  assign o_ptr = stat_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  ptr_join_a: assert property ( // [R1] [R2]
    h2_hit && !inc_hit && !dec_hit && val <= sph_pkg::PTR_MAX
    |=> stat_ff.pointer == $past(val) && !stat_ff.ptr_invalid)
    else $error("pointer not taken from joined h1 h2 word");
  ptr_invalid_a: assert property ( // [R5] [R16]
    h2_hit && !inc_hit && !dec_hit && val > sph_pkg::PTR_MAX
    |=> stat_ff.ptr_invalid && $stable(stat_ff.pointer))
    else $error("invalid pointer moved the payload");
  sync_first_a: assert property ( // [R6]
    $changed(stat_ff.pointer) |-> $past(state_ff) == sph_pkg::SPH_LOCK)
    else $error("pointer read without frame lock");
  dummy_mark_a: assert property ( // [R10]
    dummy |-> ##2 byte_ff.valid && byte_ff.stuff && !byte_ff.spe)
    else $error("low buffer did not yield a dummy byte");
  stuff_excl_a: assert property ( // [R11]
    byte_ff.stuff |-> !byte_ff.spe && !byte_ff.j1 && byte_ff.data == sph_pkg::DUMMY_BYTE)
    else $error("stuffed byte entered the payload");
  inc_step_a: assert property ( // [R13]
    h2_hit && inc_hit
    |=> stat_ff.inc
        && stat_ff.pointer == (($past(stat_ff.pointer) == sph_pkg::PTR_MAX) ? 10'h000
                               : $past(stat_ff.pointer) + 10'h001)
    ##1 !stat_ff.inc)
    else $error("increment did not raise the pointer by one");
  dec_step_a: assert property ( // [R15]
    h2_hit && dec_hit
    |=> stat_ff.dec
        && stat_ff.pointer == (($past(stat_ff.pointer) == 10'h000) ? sph_pkg::PTR_MAX
                               : $past(stat_ff.pointer) - 10'h001)
    ##1 !stat_ff.dec)
    else $error("decrement did not lower the pointer by one");
  equal_rate_a: assert property ( // [R9]
    h2_hit && val == stat_ff.pointer
    |=> !stat_ff.inc && !stat_ff.dec && $stable(stat_ff.pointer))
    else $error("adjustment made with a steady pointer");
  zero_ptr_a: assert property ( // [R4]
    lock && at_env0 && ptr_ok_ff && stat_ff.pointer == 10'h000 && !inc_frame_ff
    |=> byte_ff.j1 && byte_ff.spe)
    else $error("zero pointer did not place j1 after h3");
  pos_stuff_a: assert property ( // [R12]
    lock && at_env0 && inc_frame_ff |=> !byte_ff.spe && !byte_ff.j1)
    else $error("positive stuff byte marked as payload");
  neg_stuff_a: assert property ( // [R14]
    lock && at_h3 && dec_frame_ff && spe_on_ff |=> byte_ff.spe)
    else $error("h3 byte of a dec frame not carried as payload");
  read_step_a: assert property ( // [R8]
    pop |=> rbin_ff == $past(rbin_ff) + 1'b1)
    else $error("read pointer did not advance on a pop");
  write_step_a: assert property ( // [R7]
    @(posedge i_line_clock) disable iff (lrst_ff)
    wr_en |=> wbin_ff == $past(wbin_ff) + 1'b1)
    else $error("write pointer did not advance on a line byte");

  inc_seen_c: cover property (h2_hit && inc_hit);
  dec_seen_c: cover property (h2_hit && dec_hit);
  dummy_seen_c: cover property (byte_ff.stuff ##1 byte_ff.spe);
endmodule

// *** sph_line_src.sv ***
// line-side partner: sends sts-1 frames with a chosen pointer action per frame
`timescale 1ns/1ns
module sph_line_src (
  input wire logic i_line_clock,
  input wire logic i_run,
  input wire logic [1:0] i_mode,
  input wire logic [9:0] i_ptr,
  output logic [7:0] o_data,
  output int o_frame,
  output int o_pos
);
  // ----------------------------------------------------------------
  // frame source
  // ----------------------------------------------------------------
  // mode 0 plain, 1 inc, 2 dec, 3 raw value (out of range); latched at frame start
  logic [1:0] mode_q = 2'h0;
  logic [9:0] ptr_q = 10'h000;
  logic [15:0] word;
  int r, c, e, jpos;
  int jlast = 0;
  initial begin
    o_data = 8'h44;
    o_frame = -1;
    o_pos = 809;
  end
  always @(posedge i_line_clock) begin
    if (i_run) begin
      o_pos = (o_pos == 809) ? 0 : o_pos + 1;
      if (o_pos == 0) begin
        o_frame = o_frame + 1;
        mode_q = i_mode;
        ptr_q = i_ptr;
      end
      r = o_pos / 90;
      c = o_pos % 90;
      e = (r >= 3) ? (r - 3) * 87 + c - 3 : (r + 6) * 87 + c - 3;
      // a raw value carries no position, so the payload stays where it last was
      jpos = (mode_q == 2'h3) ? jlast : int'(ptr_q) + (mode_q == 2'h1) - (mode_q == 2'h2);
      if (o_pos == 0) begin
        jlast = jpos;
      end
      word[15:10] = 6'h18;
      word[9:0] = (mode_q == 2'h1) ? ptr_q ^ sph_pkg::INC_MASK :
                  (mode_q == 2'h2) ? ptr_q ^ sph_pkg::DEC_MASK : ptr_q;
      if (o_pos == 0) o_data <= sph_pkg::FRAME_A;
      else if (o_pos == 1) o_data <= sph_pkg::FRAME_B;
      else if (r == 3 && c == 0) o_data <= word[15:8];
      else if (r == 3 && c == 1) o_data <= word[7:0];
      else if (r == 3 && c == 2) o_data <= (mode_q == 2'h2) ? 8'h33 : 8'h77;
      else if (c < 3) o_data <= 8'h44;
      else if (mode_q == 2'h1 && e == 0) o_data <= 8'hee;
      else if (e == jpos) o_data <= 8'h5a;
      else o_data <= 8'h11;
    end
  end
endmodule

// *** sph_pointer_slip_handler_tb_top.sv ***
// testbench for the sts-1 pointer receiver fed by the line-side frame source
`timescale 1ns/1ns
module sph_pointer_slip_handler_tb_top;
  typedef struct {
    logic [1:0] mode;
    logic [9:0] ptr;
    logic [9:0] exp_ptr;
    logic [2:0] exp_flags;
    logic [7:0] exp_prev;
  } sph_row_type;
  logic i_clock = 1'b0;
  logic i_line_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_out_req = 1'b0;
  logic run = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [9:0] ptr = 10'h000;
  logic [7:0] line_data;
  sph_pkg::sph_byte_type o_byte;
  sph_pkg::sph_ptr_type o_ptr;
  int frame, pos;
  int n_fail = 0;
  int compares = 0;
  logic [1:0] req_q = 2'h0;
  logic [7:0] last_data = 8'h00;
  logic [7:0] j1_prev = 8'hff;
  logic inc_seen = 1'b0;
  logic dec_seen = 1'b0;
  logic slip_seen = 1'b0;
  sph_row_type rows [4];

  always #2 i_clock = ~i_clock;
  always #80 i_line_clock = ~i_line_clock;

  sph_pointer_rx i_sph_pointer_rx (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_line_clock(i_line_clock),
    .i_line_data(line_data),
    .i_out_req(i_out_req),
    .o_byte(o_byte),
    .o_ptr(o_ptr)
  );
  sph_line_src i_sph_line_src (
    .i_line_clock(i_line_clock),
    .i_run(run),
    .i_mode(mode),
    .i_ptr(ptr),
    .o_data(line_data),
    .o_frame(frame),
    .o_pos(pos)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // bounded wait for a byte position of a given frame at the line side
  task automatic wait_pos(input int f, input int p);
    int k;
    k = 0;
    while (!(frame == f && pos >= p) && k < 40000) begin
      step(1);
      k++;
    end
    if (k == 40000) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, frame, f);
      close_out();
    end
  endtask

  // ----------------------------------------------------------------
  // output monitor
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      req_q <= 2'h0;
    end else begin
      // a request taken at one edge shows as valid when sampled two edges later
      req_q <= {req_q[0], i_out_req};
      check(o_byte.valid, req_q[1]);
      if (o_byte.valid && !o_byte.stuff) last_data <= o_byte.data;
      if (o_byte.valid && o_byte.stuff) check({o_byte.spe, o_byte.data}, 9'h000);
      if (o_byte.valid && o_byte.j1) begin
        check({o_byte.spe, o_byte.data}, {1'b1, 8'h5a});
        j1_prev <= last_data;
      end
      if (o_byte.valid && !o_byte.stuff && o_byte.data == 8'hee) check(o_byte.spe, 1'b0);
      if (o_byte.valid && o_byte.data == 8'h33) check(o_byte.spe, 1'b1);
      if (o_ptr.inc) inc_seen <= 1'b1;
      if (o_ptr.dec) dec_seen <= 1'b1;
      if (o_ptr.slip) slip_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // flags are inc, dec, invalid; prev is the real byte just before j1
    rows[0] = '{2'h0, 10'h000, 10'h000, 3'b000, 8'h77};
    rows[1] = '{2'h1, 10'h000, 10'h001, 3'b100, 8'hee};
    rows[2] = '{2'h2, 10'h001, 10'h000, 3'b010, 8'h33};
    rows[3] = '{2'h3, 10'h310, 10'h000, 3'b001, 8'h77};
    // both domains must see reset, which takes longer than 20 local cycles here
    step(200);
    check({o_byte, o_ptr}, 32'h0);
    i_rstn = 1'b1;
    step(1);
    check({o_byte, o_ptr}, 32'h0);
    i_out_req = 1'b1;
    step(300);
    check(o_ptr.in_frame, 1'b0);
    $display("reset test done");
    foreach (rows[k]) begin
      mode = rows[k].mode;
      ptr = rows[k].ptr;
      run = 1'b1;
      inc_seen = 1'b0;
      dec_seen = 1'b0;
      j1_prev = 8'hff;
      wait_pos(k, 300);
      check(o_ptr.pointer, rows[k].exp_ptr);
      check({inc_seen, dec_seen, o_ptr.ptr_invalid}, rows[k].exp_flags);
      check(j1_prev, rows[k].exp_prev);
      check(o_ptr.in_frame, 1'b1);
      $display("row %0d done", k);
    end
    // stall the reader until the buffer overflows, then expect real bytes
    i_out_req = 1'b0;
    slip_seen = 1'b0;
    step(1800);
    check(slip_seen, 1'b1);
    i_out_req = 1'b1;
    step(1);
    i_out_req = 1'b0;
    // the answer stands for one cycle only, right after the second edge
    step(1);
    check({o_byte.valid, o_byte.stuff}, 2'b10);
    $display("overflow test done");
    close_out();
  end
endmodule
